// ===== bench/gray_shuffle_table_ops_assertions.sv
// port-level checker for the gray, shuffle and table datapath
module gray_shuffle_table_ops_assertions #(
    parameter int COPY_LIMIT = 4095
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // instruction
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire table_ops_pkg::cmd_t cmd,
    input wire logic scan_end,
    // results
    input wire logic done,
    input wire logic [table_ops_pkg::ACC_W-1:0] acc_out,
    input wire table_ops_pkg::flags_t flags,
    // memory
    input wire table_ops_pkg::mem_req_t mem_req,
    input wire logic mem_rvalid,
    input wire logic [table_ops_pkg::WORD_W-1:0] mem_rdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic take;
    logic cp;
    logic bit_ok;
    table_ops_pkg::op_t op_reg;
    logic [15:0] rd_reg;
    logic [3:0] idx_reg;
    assign take = cmd_valid && cmd_ready;
    assign cp = cmd.acc[31:16] == 16'h0;
    assign bit_ok = {4'h0, cmd.operand[15:4]} < {8'h0, cmd.stack1[7:0]};
    // -----------------------------------
    // last instruction and captured read
    // -----------------------------------
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            op_reg <= table_ops_pkg::OP_GRAY;
            rd_reg <= 16'h0;
            idx_reg <= 4'h0;
        end
        else
        begin
            if (take)
            begin
                op_reg <= cmd.op;
                idx_reg <= cmd.operand[3:0];
            end
            if (mem_rvalid)
                rd_reg <= mem_rdata;
        end
    end
    gray_upper_a: assert property (take && cmd.op == table_ops_pkg::OP_GRAY |=>
        done && acc_out[31:10] == 22'h0) else $error("gray result upper bits set");
    zero_flag_a: assert property (done && op_reg inside {table_ops_pkg::OP_GRAY,
        table_ops_pkg::OP_SHUFFLE} |-> flags.zero == (acc_out == 32'h0)) else $error("zero bad");
    neg_flag_a: assert property (done && op_reg inside {table_ops_pkg::OP_GRAY,
        table_ops_pkg::OP_SHUFFLE} |-> flags.negative == acc_out[31]) else $error("neg bad");
    void_order_a: assert property (take && cmd.op == table_ops_pkg::OP_SHUFFLE
        && cmd.acc == 32'h0 |=> acc_out == 32'h0) else $error("void order not zero");
    copy_read_a: assert property (take && cmd.op == table_ops_pkg::OP_TABLE_COPY && cp
        && cmd.stack1 != 32'h0 && cmd.stack1 <= COPY_LIMIT |=> ##1 mem_req.rd
        && !mem_req.label && mem_req.addr == $past(cmd.acc[15:0], 2))
        else $error("copy read address wrong");
    copy_limit_a: assert property (take && cmd.op == table_ops_pkg::OP_TABLE_COPY
        && cmd.stack1 > COPY_LIMIT |=> done && flags.range_err && !mem_req.rd)
        else $error("oversized copy not refused");
    label_src_a: assert property (take && cmd.op == table_ops_pkg::OP_LABEL_COPY && cp
        && cmd.stack2 != 32'h0 && cmd.stack2 <= COPY_LIMIT |=> ##1 mem_req.rd && mem_req.label
        && mem_req.addr == $past(cmd.acc[15:0] + cmd.stack1[15:0], 2)) else $error("label src");
    busy_ready_a: assert property (mem_req.rd |-> !cmd_ready)
        else $error("instruction accepted while memory busy");
    copy_data_a: assert property (mem_rvalid && op_reg inside {table_ops_pkg::OP_TABLE_COPY,
        table_ops_pkg::OP_LABEL_COPY} |=> mem_req.wr && mem_req.wdata == $past(mem_rdata))
        else $error("copy write data wrong");
    bit_addr_a: assert property (take && cmd.op inside {table_ops_pkg::OP_BIT_SET,
        table_ops_pkg::OP_BIT_CLEAR} && bit_ok |=> mem_req.rd
        && mem_req.addr == $past(cmd.acc[15:0] + {4'h0, cmd.operand[15:4]})) else $error("bit addr");
    bit_range_a: assert property (take && cmd.op inside {table_ops_pkg::OP_BIT_SET,
        table_ops_pkg::OP_BIT_CLEAR} && !bit_ok |=> done && flags.range_err && !mem_req.rd)
        else $error("bit index range not refused");
    bit_write_a: assert property (mem_req.wr && op_reg == table_ops_pkg::OP_BIT_SET |->
        mem_req.wdata == (rd_reg | (16'h1 << idx_reg))) else $error("bit set data wrong");
    bit_clear_a: assert property (mem_req.wr && op_reg == table_ops_pkg::OP_BIT_CLEAR |->
        mem_req.wdata == (rd_reg & ~(16'h1 << idx_reg))) else $error("bit clear data wrong");
    scan_clear_a: assert property (scan_end |=> done || flags == 3'h0)
        else $error("flags survive scan end");
    cover property (take && cmd.op == table_ops_pkg::OP_SHUFFLE);
    cover property (mem_req.wr && mem_req.label == 1'b0);
    cover property (done && flags.range_err);
endmodule // gray_shuffle_table_ops_assertions

bind gray_shuffle_table_ops gray_shuffle_table_ops_assertions #(.COPY_LIMIT(COPY_LIMIT)) i_chk (
    .mclk, .reset, .cmd_valid, .cmd_ready, .cmd, .scan_end, .done, .acc_out, .flags,
    .mem_req, .mem_rvalid, .mem_rdata);

// ===== bench/tb_gray_shuffle_table_ops.sv
// self-checking testbench for the gray, shuffle and table datapath
module tb_gray_shuffle_table_ops;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    table_ops_pkg::cmd_t cmd = '0;
    logic scan_end = 1'b0;
    logic done;
    logic [31:0] acc_out;
    table_ops_pkg::flags_t flags;
    table_ops_pkg::mem_req_t mem_req;
    logic mem_rvalid = 1'b0;
    logic [15:0] mem_rdata = 16'h0;
    int num_errors = 0;
    int checks_done = 0;
    int lat = 1;
    int n_rd = 0;
    int n_wr = 0;
    logic [15:0] wa;
    logic [15:0] wd;
    logic [15:0] raddr;
    logic rlab;
    gray_shuffle_table_ops #(.COPY_LIMIT(4095)) i_dut (.mclk(mclk), .reset(reset),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .scan_end(scan_end),
        .done(done), .acc_out(acc_out), .flags(flags), .mem_req(mem_req),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
    always #5 mclk = ~mclk;
    function automatic logic [15:0] mv(input logic [15:0] a, input logic lab);
        return lab ? (a ^ 16'h5a5a) : (a ^ 16'ha5a5);
    endfunction
    // ---------------------------------
    // memory: answers reads after lat
    // ---------------------------------
    initial forever
    begin
        @(posedge mclk);
        if (mem_req.wr === 1'b1)
        begin
            n_wr++;
            wa = mem_req.addr;
            wd = mem_req.wdata;
        end
        if (mem_req.rd === 1'b1)
        begin
            n_rd++;
            raddr = mem_req.addr;
            rlab = mem_req.label;
            repeat (lat) @(posedge mclk);
            #1 mem_rvalid = 1'b1;
            mem_rdata = mv(raddr, rlab);
            @(posedge mclk);
            #1 mem_rvalid = 1'b0;
            mem_rdata = ~mem_rdata;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic issue(input table_ops_pkg::op_t op, input logic [31:0] a, s1, s2,
        input logic [15:0] opnd);
        int n;
        n_rd = 0;
        n_wr = 0;
        check({31'h0, cmd_ready}, 32'h1);
        cmd = '{op: op, acc: a, stack1: s1, stack2: s2, operand: opnd};
        cmd_valid = 1'b1;
        @(posedge mclk);
        #1 cmd_valid = 1'b0;
        for (n = 0; n < 100 && done !== 1'b1; n++)
            @(posedge mclk) #1;
        check({31'h0, done}, 32'h1);
        @(posedge mclk) #1;
    endtask
    task automatic t_gray;
        issue(table_ops_pkg::OP_GRAY, 32'hffff_000a, 32'h0, 32'h0, 16'h0);
        check(acc_out, 32'h12);
        check({29'h0, flags}, 32'h0);
        issue(table_ops_pkg::OP_GRAY, 32'h0000_0080, 32'h0, 32'h0, 16'h0);
        check(acc_out, 32'h255);
        // 360-count encoder origin: program then subtracts bcd 76
        issue(table_ops_pkg::OP_GRAY, 32'h0000_006a, 32'h0, 32'h0, 16'h0);
        check(acc_out, 32'h76);
        issue(table_ops_pkg::OP_GRAY, 32'h0, 32'h0, 32'h0, 16'h0);
        check({31'h0, flags.zero}, 32'h1);
        $display("test gray finished");
    endtask
    task automatic t_shuffle;
        logic [31:0] ord [5] = '{32'h1234_5678, 32'h8765_4321, 32'h0f39_2a81,
            32'h2211_8888, 32'h0};
        logic [31:0] src;
        logic [31:0] ex;
        logic [3:0] k;
        src = 32'h8765_4321;
        foreach (ord[j])
        begin
            ex = 32'h0;
            for (int i = 0; i < 8; i++)
            begin
                k = ord[j][4*i+:4];
                if (k >= 4'h1 && k <= 4'h8)
                    ex[4*(k-1)+:4] = src[4*i+:4];
            end
            issue(table_ops_pkg::OP_SHUFFLE, ord[j], src, 32'h0, 16'h0);
            check(acc_out, ex);
            check({31'h0, flags.zero}, {31'h0, ex == 32'h0});
            check({31'h0, flags.negative}, {31'h0, ex[31]});
        end
        $display("test shuffle finished");
    endtask
    task automatic t_copy;
        issue(table_ops_pkg::OP_TABLE_COPY, 32'h40, 32'h2, 32'h0, 16'h80);
        check(n_wr, 2);
        check({wa, wd}, {16'h81, mv(16'h41, 1'b0)});
        lat = 3;
        issue(table_ops_pkg::OP_LABEL_COPY, 32'h10, 32'h3, 32'h1, 16'h20);
        check({wa, wd}, {16'h23, mv(16'h13, 1'b1)});
        issue(table_ops_pkg::OP_LABEL_COPY, 32'h10, 32'h0, 32'h1, 16'h20);
        check({wa, wd}, {16'h20, mv(16'h10, 1'b1)});
        issue(table_ops_pkg::OP_TABLE_COPY, 32'h40, 32'h1000, 32'h0, 16'h80);
        check({flags.range_err, n_rd[30:0]}, 32'h8000_0000);
        issue(table_ops_pkg::OP_TABLE_COPY, 32'h1_0040, 32'h2, 32'h0, 16'h80);
        check({flags.range_err, n_rd[30:0]}, 32'h8000_0000);
        lat = 1;
        $display("test copy finished");
    endtask
    task automatic t_bit;
        issue(table_ops_pkg::OP_BIT_SET, 32'h100, 32'h2, 32'h0, 16'o34);
        check({wa, wd}, {16'h101, mv(16'h101, 1'b0) | 16'h1000});
        issue(table_ops_pkg::OP_BIT_CLEAR, 32'h100, 32'h2, 32'h0, 16'o15);
        check({wa, wd}, {16'h100, mv(16'h100, 1'b0) & ~16'h2000});
        issue(table_ops_pkg::OP_BIT_SET, 32'h100, 32'h2, 32'h0, 16'o37);
        check({wa, wd}, {16'h101, mv(16'h101, 1'b0) | 16'h8000});
        issue(table_ops_pkg::OP_BIT_SET, 32'h100, 32'h2, 32'h0, 16'o40);
        check({flags.range_err, n_wr[30:0]}, 32'h8000_0000);
        $display("test bit finished");
    endtask
    task automatic t_scan;
        scan_end = 1'b1;
        @(posedge mclk);
        #1 scan_end = 1'b0;
        check({29'h0, flags}, 32'h0);
        $display("test scan finished");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #100000;
        num_errors++;
        wrap_up();
    end
    initial
    begin
        repeat (4) @(posedge mclk);
        #1 reset = 1'b0;
        t_gray();
        t_shuffle();
        t_copy();
        t_bit();
        t_scan();
        wrap_up();
    end
endmodule // tb_gray_shuffle_table_ops

// ===== core/gray_shuffle_table_ops.sv
// accumulator datapath for gray, shuffle, table copy and table bit ops
module gray_shuffle_table_ops #(
    parameter int COPY_LIMIT = 4095
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // instruction
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire table_ops_pkg::cmd_t cmd,
    input wire logic scan_end,
    // results
    output logic done,
    output logic [table_ops_pkg::ACC_W-1:0] acc_out,
    output table_ops_pkg::flags_t flags,
    // word / label memory
    output table_ops_pkg::mem_req_t mem_req,
    input wire logic mem_rvalid,
    input wire logic [table_ops_pkg::WORD_W-1:0] mem_rdata
);
    localparam int AW = table_ops_pkg::ADDR_W;
    localparam int WW = table_ops_pkg::WORD_W;
    localparam int AC = table_ops_pkg::ACC_W;

    // refuse a copy limit the 12-bit word counter cannot hold
    if (COPY_LIMIT < 1 || COPY_LIMIT > int'(table_ops_pkg::COPY_MAX))
    begin : g_bad_limit
        $error("COPY_LIMIT out of range");
    end

    // ----------------------------------------
    // combinational conversions
    // ----------------------------------------
    function automatic logic [AC-1:0] gray_to_bcd(input logic [AC-1:0] a);
        logic [table_ops_pkg::GRAY_W-1:0] b;
        logic [table_ops_pkg::BCD_W+3:0] bcd;
        logic [table_ops_pkg::BCD_W-1:0] v;
        b = '0;
        bcd = '0;
        b[table_ops_pkg::GRAY_W-1] = a[table_ops_pkg::GRAY_W-1];
        for (int i = table_ops_pkg::GRAY_W - 2; i >= 0; i--)
            b[i] = b[i+1] ^ a[i];
        v = b[table_ops_pkg::BCD_W-1:0];
        for (int i = table_ops_pkg::BCD_W - 1; i >= 0; i--)
        begin
            // top two bits never exceed one, so only three digits need adjusting
            for (int d = 0; d < 3; d++)
                if (bcd[d*4+:4] > 4'h4)
                    bcd[d*4+:4] = bcd[d*4+:4] + 4'h3;
            bcd = {bcd[table_ops_pkg::BCD_W+2:0], v[i]};
        end
        // result limited to 10 bits, upper bits cleared
        gray_to_bcd = {{(AC - table_ops_pkg::BCD_W){1'b0}}, bcd[table_ops_pkg::BCD_W-1:0]};
    endfunction

    function automatic logic [AC-1:0] shuffle(input logic [AC-1:0] src, input logic [AC-1:0] ord);
        logic [AC-1:0] r;
        logic [3:0] o;
        r = '0;
        // low positions first so the most significant duplicate wins
        for (int i = 0; i < table_ops_pkg::DIGITS; i++)
        begin
            o = ord[i*4+:4];
            // order digit o places source digit i at result digit o-1
            if (o >= 4'h1 && o <= 4'h8)
                r[(int'(o)-1)*4+:4] = src[i*4+:4];
            // digits 0 and 9..f place nothing, leaving zero
        end
        shuffle = r;
    endfunction

    // ----------------------------------------
    // sequencer state
    // ----------------------------------------
    table_ops_pkg::state_t state_reg, state_next;
    logic [AC-1:0] acc_reg, acc_next;
    table_ops_pkg::flags_t flags_reg, flags_next;
    logic [AW-1:0] src_reg, src_next;
    logic [AW-1:0] dst_reg, dst_next;
    logic [11:0] count_reg, count_next;
    logic label_reg, label_next;
    logic set_reg, set_next;
    logic [3:0] bitpos_reg, bitpos_next;
    logic [WW-1:0] data_reg, data_next;
    logic done_reg, done_next;
    table_ops_pkg::mem_req_t req_reg, req_next;

    logic [AW:0] bit_word;
    logic [AC-1:0] copy_count_src;

    always_comb
    begin
        state_next = state_reg;
        acc_next = acc_reg;
        flags_next = flags_reg;
        src_next = src_reg;
        dst_next = dst_reg;
        count_next = count_reg;
        label_next = label_reg;
        set_next = set_reg;
        bitpos_next = bitpos_reg;
        data_next = data_reg;
        done_next = 1'b0;
        req_next = '0;
        bit_word = '0;
        copy_count_src = '0;
        // flags only need to hold until scan end
        if (scan_end)
            flags_next = '0;
        unique case (state_reg)
            table_ops_pkg::ST_IDLE:
            begin
                if (cmd_valid)
                begin
                    unique case (cmd.op)
                        table_ops_pkg::OP_GRAY, table_ops_pkg::OP_SHUFFLE:
                        begin
                            if (cmd.op == table_ops_pkg::OP_GRAY)
                                acc_next = gray_to_bcd(cmd.acc);
                            else
                                acc_next = shuffle(cmd.stack1, cmd.acc);
                            flags_next.zero = (acc_next == '0);
                            flags_next.negative = acc_next[AC-1];
                            done_next = 1'b1;
                        end
                        table_ops_pkg::OP_TABLE_COPY, table_ops_pkg::OP_LABEL_COPY:
                        begin
                            label_next = (cmd.op == table_ops_pkg::OP_LABEL_COPY);
                            if (label_next)
                            begin
                                // count stack two, offset stack one
                                copy_count_src = cmd.stack2;
                                src_next = cmd.acc[AW-1:0] + cmd.stack1[AW-1:0];
                                dst_next = cmd.operand + cmd.stack1[AW-1:0];
                            end
                            else
                            begin
                                copy_count_src = cmd.stack1;
                                src_next = cmd.acc[AW-1:0];
                                dst_next = cmd.operand;
                            end
                            // oversize count or source beyond address range
                            if (copy_count_src > AC'(COPY_LIMIT) || cmd.acc[AC-1:AW] != '0)
                            begin
                                flags_next.range_err = 1'b1;
                                done_next = 1'b1;
                            end
                            else
                            begin
                                flags_next.range_err = 1'b0;
                                count_next = copy_count_src[11:0];
                                if (copy_count_src == '0)
                                    done_next = 1'b1;
                                else
                                    state_next = table_ops_pkg::ST_COPY_RD;
                            end
                        end
                        table_ops_pkg::OP_BIT_SET, table_ops_pkg::OP_BIT_CLEAR:
                        begin
                            set_next = (cmd.op == table_ops_pkg::OP_BIT_SET);
                            // 16 bits per word across the table
                            bit_word = {1'b0, cmd.operand} >> table_ops_pkg::BIT_SHIFT;
                            bitpos_next = cmd.operand[table_ops_pkg::BIT_SHIFT-1:0];
                            src_next = cmd.acc[AW-1:0] + bit_word[AW-1:0];
                            label_next = 1'b0;
                            // index past last bit: flag and touch nothing
                            if (bit_word >= {{(AW-7){1'b0}}, cmd.stack1[7:0]})
                            begin
                                flags_next.range_err = 1'b1;
                                done_next = 1'b1;
                            end
                            else
                            begin
                                flags_next.range_err = 1'b0;
                                req_next.rd = 1'b1;
                                req_next.addr = src_next;
                                state_next = table_ops_pkg::ST_BIT_RMW;
                            end
                        end
                        default:
                            done_next = 1'b1;
                    endcase
                end
            end
            table_ops_pkg::ST_COPY_RD:
            begin
                req_next.rd = 1'b1;
                req_next.label = label_reg;
                req_next.addr = src_reg;
                state_next = table_ops_pkg::ST_COPY_WR;
            end
            table_ops_pkg::ST_COPY_WR:
            begin
                if (mem_rvalid)
                begin
                    req_next.wr = 1'b1;
                    req_next.addr = dst_reg;
                    req_next.wdata = mem_rdata;
                    src_next = src_reg + 16'h0001;
                    dst_next = dst_reg + 16'h0001;
                    count_next = count_reg - 12'h001;
                    if (count_reg == 12'h001)
                    begin
                        state_next = table_ops_pkg::ST_IDLE;
                        done_next = 1'b1;
                    end
                    else
                        state_next = table_ops_pkg::ST_COPY_RD;
                end
            end
            table_ops_pkg::ST_BIT_RMW:
            begin
                if (mem_rvalid)
                begin
                    data_next = mem_rdata;
                    data_next[bitpos_reg] = set_reg;
                    req_next.wr = 1'b1;
                    req_next.addr = src_reg;
                    req_next.wdata = data_next;
                    state_next = table_ops_pkg::ST_IDLE;
                    done_next = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= table_ops_pkg::ST_IDLE;
            acc_reg <= '0;
            flags_reg <= '0;
            src_reg <= '0;
            dst_reg <= '0;
            count_reg <= '0;
            label_reg <= 1'b0;
            set_reg <= 1'b0;
            bitpos_reg <= '0;
            data_reg <= '0;
            done_reg <= 1'b0;
            req_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            flags_reg <= flags_next;
            src_reg <= src_next;
            dst_reg <= dst_next;
            count_reg <= count_next;
            label_reg <= label_next;
            set_reg <= set_next;
            bitpos_reg <= bitpos_next;
            data_reg <= data_next;
            done_reg <= done_next;
            req_reg <= req_next;
        end
    end

    assign cmd_ready = (state_reg == table_ops_pkg::ST_IDLE);
    assign done = done_reg;
    assign acc_out = acc_reg;
    assign flags = flags_reg;
    assign mem_req = req_reg;
endmodule // gray_shuffle_table_ops

// ===== core/table_ops_pkg.sv
// constants and types for the gray, shuffle and table datapath
package table_ops_pkg;
    localparam int ACC_W = 32;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 16;
    localparam int DIGITS = 8;
    localparam int GRAY_W = 16;
    localparam int BCD_W = 10;
    localparam logic [11:0] COPY_MAX = 12'hfff;
    localparam logic [7:0] BIT_TABLE_MAX = 8'hff;
    localparam int BIT_SHIFT = 4;

    // ----------------------------------------
    // operation codes
    // ----------------------------------------
    typedef enum logic [2:0] {
        OP_GRAY = 3'h0,
        OP_SHUFFLE = 3'h1,
        OP_TABLE_COPY = 3'h2,
        OP_LABEL_COPY = 3'h3,
        OP_BIT_SET = 3'h4,
        OP_BIT_CLEAR = 3'h5
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_COPY_RD = 2'h1,
        ST_COPY_WR = 2'h2,
        ST_BIT_RMW = 2'h3
    } state_t;

    typedef struct packed {
        op_t op;
        logic [ACC_W-1:0] acc;
        logic [ACC_W-1:0] stack1;
        logic [ACC_W-1:0] stack2;
        logic [ADDR_W-1:0] operand;
    } cmd_t;

    typedef struct packed {
        logic zero;
        logic negative;
        logic range_err;
    } flags_t;

    // memory request: label selects program-memory label area
    typedef struct packed {
        logic rd;
        logic wr;
        logic label;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } mem_req_t;
endpackage
